// >>> core/su2_top.sv
// Secondary serial port: registers, transmitter, receiver
//
// Functional notes
// - Control bit 6 set selects 9-bit characters, clear selects 8-bit.
// - In extended mode a new character arriving while receive flag is 1 sets overwrite flag.
// - Overwrite flag stays set until software writes 0 to bit 5.
// - Frame error is read-only, updated each frame, set on missing stop.
// - Break flag updated each frame, set when line low over 10.5 bits.
// - Reception runs only while software holds receive enable set.
// - Transmit flag set at end of eighth bit; only software clears it.
// - Receive flag set by hardware on a character; software clears it.
// - Data buffer is an 8-bit register, reset zero, carrying characters.
// - In 9-bit mode baud control bit 7 is sent as ninth bit.
// - Baud bit 6 latches ninth received bit, or the stop bit in 8-bit.
// - Baud bit 5 picks fractional value 0x2B when set, 0x07 when clear.
// - Baud bits 4:3 hold extended ratio added to the binary divider.
// - Baud bits 2:0 pick divide by 1 up to 128, doubling per code.
// - Registers sit at 0xE1, 0xEB and 0xEE, not bit addressable.
// - Bit rate is clock over 16, 2 to the sum, and 1 + frac/64.
// - Frame is a 0 start bit, data LSB first, then a 1 stop bit.
// - Data write starts transmission; data read returns receive register.
// - Without extended mode a character is dropped unless receive flag 0.
`timescale 1ns/1ps
module su2_top (
    input  wire logic       ref_clk_i,
    input  wire logic       rstn_i,
    input  wire logic [7:0] sfr_addr_i,
    input  wire logic       sfr_wr_i,
    input  wire logic       sfr_rd_i,
    input  wire logic [7:0] sfr_wdata_i,
    output logic      [7:0] sfr_rdata_o,
    input  wire logic       extended_serial_enable_i,
    input  wire logic       serial2_rx_pin_i,
    output logic            serial2_tx_pin_o,
    output logic            tx_queue_ready_o
);
    typedef struct packed {
        logic                 nine_bit_mode_en;
        logic                 overwrite_err_flag;
        logic                 frame_err_flag;
        logic                 break_err_flag;
        logic                 rx_enable_bit;
        logic                 tx_done_flag;
        logic                 rx_done_flag;
        logic                 ninth_tx_bit;
        logic                 ninth_rx_bit;
        logic                 frac_select_bit;
        logic [1:0]           extended_divider;
        logic [2:0]           binary_divider;
        logic [7:0]           rx_buf;
        logic [7:0]           rdata;
        su2_pkg::su2_tx_st_t  tx_st;
        logic [3:0]           tx_sub;
        logic [3:0]           tx_bit;
        logic [9:0]           tx_shift;
        logic                 tx_space;
        logic                 tx_nine;
        su2_pkg::su2_rx_st_t  rx_st;
        logic [3:0]           rx_sub;
        logic [3:0]           rx_bit;
        logic [8:0]           rx_shift;
        logic                 rx_nine;
        logic                 rx_prev_low;
        logic [7:0]           low_cnt;
    } su2_state_t;

    su2_state_t s;
    su2_state_t next_s;
    logic       tick;
    logic       wr_ctrl;
    logic       wr_baud;
    logic       tx_wrap;
    logic       tx_load;
    logic       rx_end;
    logic [3:0] tx_last;
    logic [7:0] rx_byte;
    logic       rx_ninth;

    su2_stream_if #(.W(8)) push_if ();
    su2_stream_if #(.W(8)) pop_if ();

    ////////////////////////////////////////////////////////////////////////
    // Divider and transmit queue

    su2_baud u_baud (
        .ref_clk_i  (ref_clk_i),
        .rstn_i     (rstn_i),
        .frac_sel_i (s.frac_select_bit),
        .ext_div_i  (s.extended_divider),
        .bin_div_i  (s.binary_divider),
        .tick_o     (tick)
    );

    su2_fifo #(.WIDTH(8), .DEPTH(16)) u_txq (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .wr_if     (push_if),
        .rd_if     (pop_if)
    );

    // A write that meets a full queue is lost; software polls the ready
    assign wr_ctrl = sfr_wr_i && (sfr_addr_i == su2_pkg::ADDR_CTRL);
    assign wr_baud = sfr_wr_i && (sfr_addr_i == su2_pkg::ADDR_BAUD);
    assign push_if.valid = sfr_wr_i && (sfr_addr_i == su2_pkg::ADDR_DATA);
    assign push_if.data  = sfr_wdata_i;
    assign pop_if.ready  = (s.tx_st == su2_pkg::TX_IDLE);
    assign tx_queue_ready_o = push_if.ready;

    assign tx_load = pop_if.valid && pop_if.ready;
    assign tx_wrap = (s.tx_st == su2_pkg::TX_SHIFT) && tick &&
                     (s.tx_sub == su2_pkg::SUB_LAST);
    assign tx_last = s.tx_nine ? su2_pkg::TX_LAST9 : su2_pkg::TX_LAST8;
    assign rx_end  = (s.rx_st == su2_pkg::RX_STOP) && tick &&
                     (s.rx_sub == su2_pkg::SUB_LAST) && s.rx_enable_bit;
    // 9-bit frames leave the ninth bit on top of the shifter
    assign rx_byte  = s.rx_nine ? s.rx_shift[7:0] : s.rx_shift[8:1];
    assign rx_ninth = s.rx_nine ? s.rx_shift[8] : serial2_rx_pin_i;

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_s = s;
        // Software writes come first so that a hardware set wins
        if (wr_ctrl) begin
            next_s.nine_bit_mode_en = sfr_wdata_i[su2_pkg::C_NINE];
            next_s.rx_enable_bit = sfr_wdata_i[su2_pkg::C_REN];
            if (!sfr_wdata_i[su2_pkg::C_OWE]) begin
                next_s.overwrite_err_flag = 1'b0;
            end
            if (!sfr_wdata_i[su2_pkg::C_TI]) begin
                next_s.tx_done_flag = 1'b0;
            end
            if (!sfr_wdata_i[su2_pkg::C_RI]) begin
                next_s.rx_done_flag = 1'b0;
            end
        end
        if (wr_baud) begin
            next_s.ninth_tx_bit = sfr_wdata_i[su2_pkg::B_TX9];
            next_s.frac_select_bit = sfr_wdata_i[su2_pkg::B_FRAC];
            next_s.extended_divider = sfr_wdata_i[su2_pkg::B_EXT +: 2];
            next_s.binary_divider = sfr_wdata_i[su2_pkg::B_DIV +: 3];
        end

        // Transmitter: start bit is driven at load, bits move at wraps
        if (tx_load) begin
            next_s.tx_st = su2_pkg::TX_SHIFT;
            next_s.tx_sub = 4'h0;
            next_s.tx_bit = 4'h0;
            next_s.tx_space = 1'b1;
            next_s.tx_nine = s.nine_bit_mode_en;
            next_s.tx_shift = {1'b1, s.nine_bit_mode_en ? s.ninth_tx_bit :
                               1'b1, pop_if.data};
        end else if ((s.tx_st == su2_pkg::TX_SHIFT) && tick) begin
            next_s.tx_sub = s.tx_sub + 4'h1;
            if (tx_wrap) begin
                if (s.tx_bit == tx_last) begin
                    next_s.tx_st = su2_pkg::TX_IDLE;
                end else begin
                    next_s.tx_space = !s.tx_shift[0];
                    next_s.tx_shift = {1'b1, s.tx_shift[9:1]};
                    next_s.tx_bit = s.tx_bit + 4'h1;
                end
                if (s.tx_bit == su2_pkg::TX_TI_BIT) begin
                    next_s.tx_done_flag = 1'b1;
                end
            end
        end

        // Receiver, 16 samples per bit
        if (tick) begin
            next_s.rx_prev_low = !serial2_rx_pin_i;
            if (serial2_rx_pin_i) begin
                next_s.low_cnt = 8'h00;
            end else if (s.low_cnt != su2_pkg::BREAK_SAMPLES) begin
                next_s.low_cnt = s.low_cnt + 8'h01;
            end
        end
        if (!s.rx_enable_bit) begin
            next_s.rx_st = su2_pkg::RX_IDLE;
        end else if (tick) begin
            next_s.rx_sub = s.rx_sub + 4'h1;
            case (s.rx_st)
                su2_pkg::RX_IDLE: begin
                    if (!s.rx_prev_low && !serial2_rx_pin_i) begin
                        next_s.rx_st = su2_pkg::RX_START;
                        next_s.rx_sub = 4'h0;
                        next_s.rx_nine = s.nine_bit_mode_en;
                    end
                end
                su2_pkg::RX_START: begin
                    if (s.rx_sub == su2_pkg::SUB_MID) begin
                        // A glitch shorter than half a bit is ignored
                        next_s.rx_st = serial2_rx_pin_i ? su2_pkg::RX_IDLE :
                                       su2_pkg::RX_DATA;
                        next_s.rx_sub = 4'h0;
                        next_s.rx_bit = 4'h0;
                    end
                end
                su2_pkg::RX_DATA: begin
                    if (s.rx_sub == su2_pkg::SUB_LAST) begin
                        next_s.rx_shift = {serial2_rx_pin_i,
                                           s.rx_shift[8:1]};
                        next_s.rx_bit = s.rx_bit + 4'h1;
                        if (s.rx_bit == (s.rx_nine ? su2_pkg::RX_LAST9 :
                                         su2_pkg::RX_LAST8)) begin
                            next_s.rx_st = su2_pkg::RX_STOP;
                        end
                    end
                end
                su2_pkg::RX_STOP: begin
                    if (s.rx_sub == su2_pkg::SUB_LAST) begin
                        next_s.rx_st = su2_pkg::RX_IDLE;
                    end
                end
                default: begin
                    next_s.rx_st = su2_pkg::RX_IDLE;
                end
            endcase
        end

        if (rx_end) begin
            next_s.frame_err_flag = !serial2_rx_pin_i;
            next_s.break_err_flag = 1'b0;
            if (extended_serial_enable_i || !s.rx_done_flag) begin
                next_s.rx_buf = rx_byte;
                next_s.ninth_rx_bit = rx_ninth;
                next_s.rx_done_flag = 1'b1;
                if (s.rx_done_flag) begin
                    next_s.overwrite_err_flag = 1'b1;
                end
            end
        end
        if (tick && !serial2_rx_pin_i &&
            (s.low_cnt == su2_pkg::BREAK_SAMPLES - 8'h01)) begin
            next_s.break_err_flag = 1'b1;
        end

        // Registered read data; unmapped addresses answer zero
        if (sfr_rd_i) begin
            case (sfr_addr_i)
                su2_pkg::ADDR_CTRL: next_s.rdata = {1'b0, s.nine_bit_mode_en,
                    s.overwrite_err_flag, s.frame_err_flag, s.break_err_flag,
                    s.rx_enable_bit, s.tx_done_flag, s.rx_done_flag};
                su2_pkg::ADDR_DATA: next_s.rdata = s.rx_buf;
                su2_pkg::ADDR_BAUD: next_s.rdata = {s.ninth_tx_bit,
                    s.ninth_rx_bit, s.frac_select_bit, s.extended_divider,
                    s.binary_divider};
                default: next_s.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            s <= '0;
            {s.nine_bit_mode_en, s.overwrite_err_flag, s.frame_err_flag,
             s.break_err_flag, s.rx_enable_bit, s.tx_done_flag,
             s.rx_done_flag} <= su2_pkg::CTRL_RST[6:0];
            s.rx_buf <= su2_pkg::DATA_RST;
            {s.ninth_tx_bit, s.ninth_rx_bit, s.frac_select_bit,
             s.extended_divider, s.binary_divider} <= su2_pkg::BAUD_RST;
        end else begin
            s <= next_s;
        end
    end

    assign serial2_tx_pin_o = !s.tx_space;
    assign sfr_rdata_o = s.rdata;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rstn_i);

    sequence s_rx_frame_end;
        rx_end;
    endsequence

    sequence s_tx_begin;
        tx_load;
    endsequence

    a_ti_at_bit8: assert property (tx_wrap && s.tx_bit == 4'h8
        |=> s.tx_done_flag) else $error("transmit flag not set");
    a_ti_held: assert property (s.tx_done_flag &&
        !(wr_ctrl && !sfr_wdata_i[su2_pkg::C_TI]) |=> s.tx_done_flag)
        else $error("transmit flag lost");
    a_ri_held: assert property (s.rx_done_flag &&
        !(wr_ctrl && !sfr_wdata_i[su2_pkg::C_RI]) |=> s.rx_done_flag)
        else $error("receive flag lost");
    a_owe_set: assert property (s_rx_frame_end ##0
        (s.rx_done_flag && extended_serial_enable_i)
        |=> s.overwrite_err_flag && s.rx_done_flag)
        else $error("overwrite not flagged");
    a_owe_clear: assert property (wr_ctrl &&
        !sfr_wdata_i[su2_pkg::C_OWE] && !(rx_end && s.rx_done_flag)
        |=> !s.overwrite_err_flag) else $error("overwrite not cleared");
    a_fe_update: assert property (s_rx_frame_end
        |=> s.frame_err_flag == !$past(serial2_rx_pin_i))
        else $error("frame error not updated");
    a_ren_off: assert property (!s.rx_enable_bit
        |=> s.rx_st == su2_pkg::RX_IDLE) else $error("receiver not idle");
    a_drop_keeps: assert property (s_rx_frame_end ##0
        (!extended_serial_enable_i && s.rx_done_flag)
        |=> $stable(s.rx_buf) && $stable(s.ninth_rx_bit) &&
            (!s.overwrite_err_flag || $past(s.overwrite_err_flag)))
        else $error("character not discarded");
    a_start_low: assert property (s_tx_begin
        |=> !serial2_tx_pin_o ##1 !serial2_tx_pin_o)
        else $error("start bit missing");
    a_rd_rxbuf: assert property (sfr_rd_i &&
        sfr_addr_i == su2_pkg::ADDR_DATA
        |=> sfr_rdata_o == $past(s.rx_buf)) else $error("bad read data");
endmodule

// >>> core/su2_pkg.sv
// Constants and types shared by the secondary serial port
package su2_pkg;
    // Register addresses
    localparam logic [7:0] ADDR_CTRL = 8'he1;
    localparam logic [7:0] ADDR_DATA = 8'heb;
    localparam logic [7:0] ADDR_BAUD = 8'hee;
    // Control/status bit positions
    localparam int C_NINE = 6;
    localparam int C_OWE  = 5;
    localparam int C_FE   = 4;
    localparam int C_BE   = 3;
    localparam int C_REN  = 2;
    localparam int C_TI   = 1;
    localparam int C_RI   = 0;
    // Baud control bit positions
    localparam int B_TX9  = 7;
    localparam int B_RX9  = 6;
    localparam int B_FRAC = 5;
    localparam int B_EXT  = 3;
    localparam int B_DIV  = 0;
    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] BAUD_RST = 8'h00;
    // Fractional divider
    localparam logic [6:0] FRAC_SET = 7'h2b;
    localparam logic [6:0] FRAC_CLR = 7'h07;
    localparam logic [6:0] FRAC_ONE = 7'h40;
    // Oversampling and break timing, in sample ticks
    localparam logic [3:0] SUB_LAST = 4'hf;
    localparam logic [3:0] SUB_MID  = 4'h7;
    localparam logic [7:0] BREAK_SAMPLES = 8'ha8;
    // Bit counts
    localparam logic [3:0] TX_LAST8 = 4'h9;
    localparam logic [3:0] TX_LAST9 = 4'ha;
    localparam logic [3:0] TX_TI_BIT = 4'h8;
    localparam logic [3:0] RX_LAST8 = 4'h7;
    localparam logic [3:0] RX_LAST9 = 4'h8;

    typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} su2_tx_st_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} su2_rx_st_t;
endpackage

// >>> core/su2_stream_if.sv
// Valid/ready word stream between the port and its queue
`timescale 1ns/1ps
interface su2_stream_if #(parameter int W = 8) ();
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport sink   (input valid, input data, output ready);
    modport source (output valid, output data, input ready);
endinterface

// >>> core/su2_fifo.sv
// Transmit queue, power-of-two depth
`timescale 1ns/1ps
module su2_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic      ref_clk_i,
    input  wire logic      rstn_i,
    su2_stream_if.sink     wr_if,
    su2_stream_if.source   rd_if
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || DEPTH != (1 << AW)) begin : g_chk
        $error("su2_fifo: DEPTH must be a power of two");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wp;
        logic [AW:0]                 rp;
    } su2_fifo_st_t;

    su2_fifo_st_t s;
    su2_fifo_st_t next_s;
    logic         full;
    logic         empty;

    assign empty = (s.wp == s.rp);
    assign full  = (s.wp[AW] != s.rp[AW]) && (s.wp[AW-1:0] == s.rp[AW-1:0]);
    assign wr_if.ready = !full;
    assign rd_if.valid = !empty;
    assign rd_if.data  = s.mem[s.rp[AW-1:0]];

    always_comb begin
        next_s = s;
        if (wr_if.valid && !full) begin
            next_s.mem[s.wp[AW-1:0]] = wr_if.data;
            next_s.wp = s.wp + {{AW{1'b0}}, 1'b1};
        end
        if (rd_if.ready && !empty) begin
            next_s.rp = s.rp + {{AW{1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    a_fill_level: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        wr_if.valid && !full && !(rd_if.ready && !empty)
        |=> (s.wp - s.rp) == $past(s.wp - s.rp) + 1'b1)
        else $error("queue level did not grow on push");
endmodule

// >>> core/su2_baud.sv
// Integer and fractional divider making the 16x sample tick
`timescale 1ns/1ps
module su2_baud (
    input  wire logic       ref_clk_i,
    input  wire logic       rstn_i,
    input  wire logic       frac_sel_i,
    input  wire logic [1:0] ext_div_i,
    input  wire logic [2:0] bin_div_i,
    output logic            tick_o
);
    typedef struct packed {
        logic [17:0] acc;
        logic        tick;
    } su2_baud_st_t;

    su2_baud_st_t s;
    su2_baud_st_t next_s;
    logic [6:0]   frac;
    logic [3:0]   expo;
    logic [17:0]  limit;
    logic [17:0]  sum;
    logic [17:0]  rem;

    // Period of one tick is limit/64 clocks; the remainder carries the fraction
    always_comb begin
        frac  = frac_sel_i ? su2_pkg::FRAC_SET : su2_pkg::FRAC_CLR;
        expo  = {2'b00, ext_div_i} + {1'b0, bin_div_i};
        limit = {11'h000, su2_pkg::FRAC_ONE + frac} << expo;
        sum   = s.acc + {11'h000, su2_pkg::FRAC_ONE};
        rem   = sum - limit;
        next_s = s;
        next_s.tick = 1'b0;
        if (sum >= limit) begin
            next_s.tick = 1'b1;
            // A shrinking divider would otherwise leave a huge backlog
            next_s.acc = (rem < limit) ? rem : 18'h00000;
        end else begin
            next_s.acc = sum;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick_o = s.tick;

    a_acc_bound: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        $stable(limit) |-> s.acc < limit)
        else $error("divider remainder out of range");
endmodule

// >>> verif/su2_peer.sv
// Remote serial peer: drives the receive line, decodes the transmit line
`timescale 1ns/1ps
module su2_peer (
    input  wire logic       clk_i,
    input  wire logic       tx_i,
    input  wire logic       nine_i,
    input  wire logic [7:0] bit_cyc_i,
    output logic            rx_o
);
    logic [8:0] got;
    logic       got_stop;
    int         frames;

    initial begin
        rx_o = 1'b1;
        got = 9'h000;
        got_stop = 1'b0;
        frames = 0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Line returns high after a frame, as a pulled-up idle line would
    task automatic send(input logic [7:0] d, input logic stop,
                        input int extra);
        @(posedge clk_i);
        rx_o <= 1'b0;
        repeat (bit_cyc_i) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            rx_o <= d[i];
            repeat (bit_cyc_i) @(posedge clk_i);
        end
        rx_o <= stop;
        repeat ((1 + extra) * bit_cyc_i) @(posedge clk_i);
        rx_o <= 1'b1;
    endtask

    // Low pulse shorter than half a bit, to be rejected as a false start
    task automatic glitch(input int n);
        @(posedge clk_i);
        rx_o <= 1'b0;
        repeat (n) @(posedge clk_i);
        rx_o <= 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Mid-bit sampling, so a divider off by one step garbles the byte
    always begin
        @(posedge clk_i);
        if (tx_i === 1'b0) begin
            got = 9'h000;
            repeat (bit_cyc_i / 2) @(posedge clk_i);
            for (int i = 0; i < 9; i++) begin
                if (i < 8 || nine_i) begin
                    repeat (bit_cyc_i) @(posedge clk_i);
                    got[i] = tx_i;
                end
            end
            repeat (bit_cyc_i) @(posedge clk_i);
            got_stop = tx_i;
            frames = frames + 1;
        end
    end
endmodule

// >>> verif/testbench.sv
// Self-checking bench for the secondary serial port
`timescale 1ns/1ps
module testbench;
    logic       ref_clk;
    logic       rstn;
    logic [7:0] sfr_addr;
    logic       sfr_wr;
    logic       sfr_rd;
    logic [7:0] sfr_wdata;
    logic [7:0] sfr_rdata;
    logic       ext_en;
    logic       rx_line;
    logic       tx_line;
    logic       q_ready;
    logic       nine;
    logic [7:0] bit_cyc;
    logic [7:0] rv;
    int         miscompares;
    int         num_checks;

    su2_top dut_u (.ref_clk_i(ref_clk), .rstn_i(rstn),
        .sfr_addr_i(sfr_addr), .sfr_wr_i(sfr_wr), .sfr_rd_i(sfr_rd),
        .sfr_wdata_i(sfr_wdata), .sfr_rdata_o(sfr_rdata),
        .extended_serial_enable_i(ext_en), .serial2_rx_pin_i(rx_line),
        .serial2_tx_pin_o(tx_line), .tx_queue_ready_o(q_ready));
    su2_peer peer_u (.clk_i(ref_clk), .tx_i(tx_line), .nine_i(nine),
        .bit_cyc_i(bit_cyc), .rx_o(rx_line));

    initial ref_clk = 1'b0;
    always #50 ref_clk = ~ref_clk;

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge ref_clk);
        sfr_wr <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge ref_clk);
        sfr_rd <= 1'b0;
        #1;
        chk(sfr_rdata, exp);
    endtask

    task automatic wait_frames(input int n);
        int k;
        k = 0;
        while (peer_u.frames < n && k < 30000) begin
            @(posedge ref_clk);
            k++;
        end
        if (k >= 30000) miscompares++;
    endtask

    task automatic finish_test();
        $display("checks=%0d miscompares=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        rchk(su2_pkg::ADDR_CTRL, 8'h00);
        rchk(su2_pkg::ADDR_DATA, 8'h00);
        rchk(su2_pkg::ADDR_BAUD, 8'h00);
        wr(8'he2, 8'hff);
        rchk(8'he2, 8'h00);
        rchk(su2_pkg::ADDR_CTRL, 8'h00);
        wr(su2_pkg::ADDR_CTRL, 8'hff);
        rchk(su2_pkg::ADDR_CTRL, 8'h44);
        wr(su2_pkg::ADDR_CTRL, 8'h00);
        wr(su2_pkg::ADDR_BAUD, 8'hff);
        rchk(su2_pkg::ADDR_BAUD, 8'hbf);
        wr(su2_pkg::ADDR_BAUD, 8'h02);
    endtask

    // Divide by 4 with the small fraction gives exactly 71 clocks a bit
    task automatic t_tx8();
        int n0;
        n0 = peer_u.frames;
        wr(su2_pkg::ADDR_DATA, 8'ha5);
        wait_frames(n0 + 1);
        chk(peer_u.got[7:0], 8'ha5);
        chk({7'h00, peer_u.got_stop}, 8'h01);
        rchk(su2_pkg::ADDR_CTRL, 8'h02);
        wr(su2_pkg::ADDR_CTRL, 8'h00);
        rchk(su2_pkg::ADDR_CTRL, 8'h00);
    endtask

    // Large fraction stretches the bit to 107 clocks
    task automatic t_tx9();
        int n0;
        n0 = peer_u.frames;
        nine <= 1'b1;
        bit_cyc <= 8'd107;
        wr(su2_pkg::ADDR_CTRL, 8'h40);
        wr(su2_pkg::ADDR_BAUD, 8'ha9);
        wr(su2_pkg::ADDR_DATA, 8'h3c);
        wait_frames(n0 + 1);
        chk(peer_u.got[7:0], 8'h3c);
        chk({7'h00, peer_u.got[8]}, 8'h01);
        // Ninth bit 0, stop 1: an 8-bit receiver would see a frame error
        wr(su2_pkg::ADDR_CTRL, 8'h44);
        peer_u.send(8'hc3, 1'b0, 0);
        repeat (107) @(posedge ref_clk);
        rchk(su2_pkg::ADDR_CTRL, 8'h45);
        rchk(su2_pkg::ADDR_DATA, 8'hc3);
        rchk(su2_pkg::ADDR_BAUD, 8'ha9);
        wr(su2_pkg::ADDR_CTRL, 8'h00);
        wr(su2_pkg::ADDR_BAUD, 8'h02);
        nine <= 1'b0;
        bit_cyc <= 8'd71;
    endtask

    task automatic t_rx();
        wr(su2_pkg::ADDR_CTRL, 8'h04);
        peer_u.send(8'h5a, 1'b1, 0);
        rchk(su2_pkg::ADDR_CTRL, 8'h05);
        rchk(su2_pkg::ADDR_DATA, 8'h5a);
        rchk(su2_pkg::ADDR_BAUD, 8'h42);
        ext_en <= 1'b1;
        peer_u.send(8'h11, 1'b1, 0);
        rchk(su2_pkg::ADDR_CTRL, 8'h25);
        rchk(su2_pkg::ADDR_DATA, 8'h11);
        wr(su2_pkg::ADDR_CTRL, 8'h05);
        rchk(su2_pkg::ADDR_CTRL, 8'h05);
        ext_en <= 1'b0;
        peer_u.send(8'h22, 1'b1, 0);
        rchk(su2_pkg::ADDR_DATA, 8'h11);
        rchk(su2_pkg::ADDR_CTRL, 8'h05);
    endtask

    // Null byte with the line held low past the stop bit
    task automatic t_break();
        wr(su2_pkg::ADDR_CTRL, 8'h04);
        peer_u.send(8'h00, 1'b0, 2);
        rchk(su2_pkg::ADDR_CTRL, 8'h1d);
        rchk(su2_pkg::ADDR_BAUD, 8'h02);
        wr(su2_pkg::ADDR_CTRL, 8'h04);
        rchk(su2_pkg::ADDR_CTRL, 8'h1c);
        peer_u.glitch(20);
        repeat (800) @(posedge ref_clk);
        rchk(su2_pkg::ADDR_CTRL, 8'h1c);
        peer_u.send(8'h66, 1'b1, 0);
        rchk(su2_pkg::ADDR_CTRL, 8'h05);
        wr(su2_pkg::ADDR_CTRL, 8'h00);
        peer_u.send(8'h77, 1'b1, 0);
        rchk(su2_pkg::ADDR_CTRL, 8'h00);
        rchk(su2_pkg::ADDR_DATA, 8'h66);
    endtask

    // First byte leaves at once, so the queue refuses after seventeen
    task automatic t_queue();
        int n0;
        int n;
        n0 = peer_u.frames;
        n = 0;
        while (q_ready === 1'b1 && n < 20) begin
            wr(su2_pkg::ADDR_DATA, n[7:0]);
            n++;
            #1;
        end
        chk(n[7:0], 8'h11);
        wait_frames(n0 + 17);
        chk(peer_u.got[7:0], 8'h10);
        chk({7'h00, q_ready}, 8'h01);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        miscompares = 0;
        num_checks = 0;
        rstn = 1'b0;
        sfr_addr = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_wdata = 8'h00;
        ext_en = 1'b0;
        nine = 1'b0;
        bit_cyc = 8'd71;
        repeat (8) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        t_regs();
        t_tx8();
        t_tx9();
        t_rx();
        t_break();
        t_queue();
        finish_test();
    end

    initial begin
        #8000000;
        miscompares++;
        finish_test();
    end
endmodule
